// ### include/rhg_pkg.sv
package rhg_pkg;

  // Port count and bus sizes
  localparam int RHG_NUM_PORTS = 15;
  localparam int RHG_ADDR_W = 8;
  localparam int RHG_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] RHG_OFS_STATUS = 8'h00;
  localparam logic [7:0] RHG_OFS_MODE = 8'h04;
  localparam logic [7:0] RHG_OFS_MASK = 8'h08;
  localparam logic [7:0] RHG_OFS_PWR = 8'h0C;
  localparam logic [7:0] RHG_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] RHG_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] RHG_OFS_PORTPWR = 8'h18;
  localparam logic [7:0] RHG_OFS_SUSPEND = 8'h1C;

  // Global status field positions
  localparam int RHG_BIT_LOCAL_STATE = 0;
  localparam int RHG_BIT_OC_FLAG = 1;
  localparam int RHG_BIT_WAKE_EN = 15;
  localparam int RHG_BIT_LOCAL_CHANGE = 16;
  localparam int RHG_BIT_OC_CHANGE = 17;
  localparam int RHG_BIT_WAKE_CLR = 31;

  // Mode register fields
  localparam int RHG_BIT_PER_PORT = 0;
  localparam int RHG_BIT_OC_PER_PORT = 1;

  // Per-port power command fields: set in [15:1], clear in [31:17]
  localparam int RHG_PORTPWR_SET_LSB = 1;
  localparam int RHG_PORTPWR_CLR_LSB = 17;

  // Interrupt status layout
  localparam int RHG_IRQ_RESUME = 0;
  localparam int RHG_IRQ_OC_CHANGE = 1;
  localparam int RHG_IRQ_W = 2;

  // Reset values
  localparam logic [15:0] RHG_RST_MASK = 16'h0000;
  localparam logic [15:0] RHG_RST_PWR = 16'h0000;
  localparam logic [1:0] RHG_RST_MODE = 2'h0;

  // AHB-Lite encodings
  localparam logic [1:0] RHG_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RHG_HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [RHG_ADDR_W-1:0] addr;
  } rhg_access_type;

  typedef struct packed {
    logic per_port;
    logic oc_per_port;
  } rhg_mode_type;

  typedef enum logic [1:0] {
    RHG_ST_OPERATIONAL,
    RHG_ST_SUSPENDED,
    RHG_ST_RESUMING
  } rhg_bus_state_type;

endpackage

// ### hw/rhg_global_status.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RL1] Local supply state and its change bit always read zero.
// [RL2] Global mode: power-off strobe clears power on every port.
// [RL3] Per-port mode: power-off strobe clears only ports with mask bit zero.
// [RL4] Global mode: power-on strobe powers every port.
// [RL5] Per-port mode: power-on strobe powers only ports with mask zero.
// [RL6] Zero written to any strobe or change flag changes nothing.
// [RL7] Global reporting: overcurrent flag follows the overcurrent condition.
// [RL8] Per-port overcurrent protection: global overcurrent flag reads zero.
// [RL9] Any change of the overcurrent flag sets its change flag.
// [RL10] Overcurrent change flag is write-one-to-clear.
// [RL11] Wake enabled: attach change in suspend resumes, raises resume interrupt.
// [RL12] Wake enable one makes attach changes wakeup events.
// [RL13] One to wake set strobe sets wake enable.
// [RL14] One to wake clear strobe clears wake enable.
// [RL15] Per-port mode: masked ports change power only through per-port commands.
// [RL16] Reserved status bits read zero and ignore writes.
module rhg_global_status
  import rhg_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Root hub side
  input wire logic overcurrent_in,
  input wire logic [RHG_NUM_PORTS:1] attach_change_flag_in,
  output logic [RHG_NUM_PORTS:1] port_power_state_out,
  output logic [1:0] bus_state_out,
  output logic resume_seen_interrupt_out,
  // Interrupt
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus capture

  rhg_access_type acc_r;
  rhg_mode_type mode_r;
  logic [RHG_NUM_PORTS:1] ganged_exclusion_mask_r;
  logic [RHG_NUM_PORTS:1] port_power_state_r;
  logic connect_wake_enable_r;
  logic overcurrent_flag_r;
  logic overcurrent_flag_change_r;
  logic [RHG_IRQ_W-1:0] irq_stat_r;
  logic [RHG_IRQ_W-1:0] irq_mask_r;
  logic resume_pulse_r;
  rhg_bus_state_type bus_state_r;
  logic [31:0] rdata_nxt;
  logic wr_en;
  logic rd_en;
  logic oc_flag_nxt;
  logic resume_event;

  function automatic logic hit(input rhg_access_type a, input logic [7:0] o);
    hit = a.valid && (a.addr == o);
  endfunction

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      acc_r <= '0;
    end else if (hready_in) begin
      acc_r.valid <= hsel_in && (htrans_in == RHG_HTRANS_NONSEQ ||
                                 htrans_in == RHG_HTRANS_SEQ);
      acc_r.write <= hwrite_in;
      acc_r.addr <= haddr_in[RHG_ADDR_W-1:0];
    end
  end

  // Zero wait states: every data phase completes in one cycle
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign wr_en = acc_r.valid && acc_r.write;
  assign rd_en = acc_r.valid && !acc_r.write;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic wr_status;
  logic wr_mode;
  logic wr_mask;
  logic wr_portpwr;
  logic wr_suspend;
  logic wr_irq_mask;

  // One decoder per register keeps every write enable a single gate
  assign wr_status = wr_en && hit(acc_r, RHG_OFS_STATUS);
  assign wr_mode = wr_en && hit(acc_r, RHG_OFS_MODE);
  assign wr_mask = wr_en && hit(acc_r, RHG_OFS_MASK);
  assign wr_portpwr = wr_en && hit(acc_r, RHG_OFS_PORTPWR);
  assign wr_suspend = wr_en && hit(acc_r, RHG_OFS_SUSPEND);
  assign wr_irq_mask = wr_en && hit(acc_r, RHG_OFS_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mode_r <= RHG_RST_MODE;
    end else if (wr_mode) begin
      mode_r.per_port <= hwdata_in[RHG_BIT_PER_PORT];
      mode_r.oc_per_port <= hwdata_in[RHG_BIT_OC_PER_PORT];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ganged_exclusion_mask_r <= RHG_RST_MASK[RHG_NUM_PORTS:1];
    end else if (wr_mask) begin
      ganged_exclusion_mask_r <= hwdata_in[RHG_NUM_PORTS:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port power

  logic glob_on;
  logic glob_off;
  logic [RHG_NUM_PORTS:1] glob_sel;
  logic [RHG_NUM_PORTS:1] pp_set;
  logic [RHG_NUM_PORTS:1] pp_clr;
  logic st_wr;

  assign st_wr = wr_status;
  // [RL6] Only ones act
  assign glob_off = st_wr && hwdata_in[RHG_BIT_LOCAL_STATE];
  assign glob_on = st_wr && hwdata_in[RHG_BIT_LOCAL_CHANGE];
  // [RL15] In per-port mode masked ports ignore global commands
  assign glob_sel = mode_r.per_port ? ~ganged_exclusion_mask_r
                                    : {RHG_NUM_PORTS{1'b1}};
  assign pp_set = wr_portpwr ?
    hwdata_in[RHG_PORTPWR_SET_LSB +: RHG_NUM_PORTS] : '0;
  assign pp_clr = wr_portpwr ?
    hwdata_in[RHG_PORTPWR_CLR_LSB +: RHG_NUM_PORTS] : '0;

  logic [RHG_NUM_PORTS:1] port_power_nxt;

  // Per-port commands only reach masked ports in per-port mode
  always_comb begin
    port_power_nxt = port_power_state_r;
    for (int i = 1; i <= RHG_NUM_PORTS; i++) begin
      // [RL2] [RL3] Global power off
      if (glob_off && glob_sel[i]) begin
        port_power_nxt[i] = 1'b0;
      // [RL4] [RL5] Global power on
      end else if (glob_on && glob_sel[i]) begin
        port_power_nxt[i] = 1'b1;
      // [RL15] Per-port commands, clear wins
      end else if (mode_r.per_port && ganged_exclusion_mask_r[i]) begin
        if (pp_clr[i]) begin
          port_power_nxt[i] = 1'b0;
        end else if (pp_set[i]) begin
          port_power_nxt[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      port_power_state_r <= RHG_RST_PWR[RHG_NUM_PORTS:1];
    end else begin
      port_power_state_r <= port_power_nxt;
    end
  end

  assign port_power_state_out = port_power_state_r;

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent

  // [RL7] [RL8] Flag follows input unless protection is per port
  assign oc_flag_nxt = mode_r.oc_per_port ? 1'b0 : overcurrent_in;

  // Seen before the flag register moves, so the change flag and the
  // interrupt status set on the same edge as the flag itself
  logic oc_changed;
  assign oc_changed = oc_flag_nxt != overcurrent_flag_r;

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      overcurrent_flag_r <= 1'b0;
    end else begin
      overcurrent_flag_r <= oc_flag_nxt;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      overcurrent_flag_change_r <= 1'b0;
    // [RL9] Flag changed
    end else if (oc_changed) begin
      overcurrent_flag_change_r <= 1'b1;
    // [RL10] Write one to clear
    end else if (st_wr && hwdata_in[RHG_BIT_OC_CHANGE]) begin
      overcurrent_flag_change_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote wakeup and suspend state

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      connect_wake_enable_r <= 1'b0;
    // [RL14] Clear strobe
    end else if (st_wr && hwdata_in[RHG_BIT_WAKE_CLR]) begin
      connect_wake_enable_r <= 1'b0;
    // [RL13] Set strobe
    end else if (st_wr && hwdata_in[RHG_BIT_WAKE_EN]) begin
      connect_wake_enable_r <= 1'b1;
    end
  end

  // [RL11] [RL12] Attach change wakes only when enabled
  assign resume_event = connect_wake_enable_r && (|attach_change_flag_in) &&
                        bus_state_r == RHG_ST_SUSPENDED;

  rhg_bus_state_type bus_state_nxt;

  // Software drives suspend entry and leaving the resuming state;
  // a wake event outranks a software write in the same cycle
  always_comb begin
    bus_state_nxt = bus_state_r;
    if (resume_event) begin
      bus_state_nxt = RHG_ST_RESUMING;
    end else if (wr_suspend) begin
      case (hwdata_in[1:0])
        2'h1: begin
          bus_state_nxt = RHG_ST_SUSPENDED;
        end
        2'h2: begin
          bus_state_nxt = RHG_ST_RESUMING;
        end
        default: begin
          bus_state_nxt = RHG_ST_OPERATIONAL;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      bus_state_r <= RHG_ST_OPERATIONAL;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      resume_pulse_r <= 1'b0;
    end else begin
      resume_pulse_r <= resume_event;
    end
  end

  assign bus_state_out = bus_state_r;
  assign resume_seen_interrupt_out = resume_pulse_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic irq_rd;
  logic [RHG_IRQ_W-1:0] irq_set;

  assign irq_rd = rd_en && hit(acc_r, RHG_OFS_IRQ_STAT);
  assign irq_set[RHG_IRQ_RESUME] = resume_event;
  assign irq_set[RHG_IRQ_OC_CHANGE] = oc_changed;

  logic [RHG_IRQ_W-1:0] irq_stat_nxt;

  // Read clears; an event in the same cycle survives
  always_comb begin
    if (irq_rd) begin
      irq_stat_nxt = irq_set;
    end else begin
      irq_stat_nxt = irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      irq_mask_r <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_r <= hwdata_in[RHG_IRQ_W-1:0];
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    // [RL1] Local supply bits stay zero
    status_word[RHG_BIT_LOCAL_STATE] = 1'b0;
    status_word[RHG_BIT_LOCAL_CHANGE] = 1'b0;
    status_word[RHG_BIT_OC_FLAG] = overcurrent_flag_r;
    status_word[RHG_BIT_WAKE_EN] = connect_wake_enable_r;
    status_word[RHG_BIT_OC_CHANGE] = overcurrent_flag_change_r;
    // [RL16] Reserved bits and the clear strobe read zero
    status_word[RHG_BIT_WAKE_CLR] = 1'b0;
  end

  always_comb begin
    rdata_nxt = '0;
    case (acc_r.addr)
      RHG_OFS_STATUS: begin
        rdata_nxt = status_word;
      end
      RHG_OFS_MODE: begin
        rdata_nxt[RHG_BIT_PER_PORT] = mode_r.per_port;
        rdata_nxt[RHG_BIT_OC_PER_PORT] = mode_r.oc_per_port;
      end
      RHG_OFS_MASK: begin
        rdata_nxt[RHG_NUM_PORTS:1] = ganged_exclusion_mask_r;
      end
      RHG_OFS_PWR: begin
        rdata_nxt[RHG_NUM_PORTS:1] = port_power_state_r;
      end
      RHG_OFS_IRQ_STAT: begin
        rdata_nxt[RHG_IRQ_W-1:0] = irq_stat_r;
      end
      RHG_OFS_IRQ_MASK: begin
        rdata_nxt[RHG_IRQ_W-1:0] = irq_mask_r;
      end
      RHG_OFS_SUSPEND: begin
        rdata_nxt[1:0] = bus_state_r;
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
    if (!rd_en) begin
      rdata_nxt = '0;
    end
  end

  // Read data is combinational from registers within the data phase
  assign hrdata_out = rdata_nxt;

endmodule
`default_nettype wire

// ### tb/rhg_global_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rhg_global_status_chk
  import rhg_pkg::*;
(
  // Clock, reset and bus
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  // Root hub side
  input wire logic overcurrent_in,
  input wire logic [RHG_NUM_PORTS:1] attach_change_flag_in,
  input wire logic [RHG_NUM_PORTS:1] port_power_state_out,
  input wire logic [1:0] bus_state_out,
  input wire logic resume_seen_interrupt_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic dv_r, dw_r, pp_r, ocp_r, wk_r, ws, rs;
  logic [7:0] da_r;
  logic [RHG_NUM_PORTS:1] mk_r, ef;
  assign ws = dv_r && dw_r && da_r == RHG_OFS_STATUS;
  assign rs = dv_r && !dw_r && da_r == RHG_OFS_STATUS;
  // Only masked ports are exempt, and only in per-port mode
  assign ef = pp_r ? mk_r : '0;
  ////////////////////////////////////////////////
  // Shadow of the control state written over the bus
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      dv_r <= 1'b0;
      dw_r <= 1'b0;
      da_r <= 8'h00;
      pp_r <= 1'b0;
      ocp_r <= 1'b0;
      wk_r <= 1'b0;
      mk_r <= '0;
    end else begin
      dv_r <= hsel_in && hready_in && htrans_in[1];
      dw_r <= hwrite_in;
      da_r <= haddr_in[7:0];
      if (dv_r && dw_r && da_r == RHG_OFS_MODE) begin
        {ocp_r, pp_r} <= hwdata_in[1:0];
      end
      if (dv_r && dw_r && da_r == RHG_OFS_MASK) begin
        mk_r <= hwdata_in[RHG_NUM_PORTS:1];
      end
      if (ws && hwdata_in[31]) begin
        wk_r <= 1'b0;
      end else if (ws && hwdata_in[15]) begin
        wk_r <= 1'b1;
      end
    end
  end
  sequence s_wake;
    wk_r && bus_state_out == 2'h1 && |attach_change_flag_in;
  endsequence
  sequence s_resume;
    bus_state_out == 2'h2 && resume_seen_interrupt_out;
  endsequence
  a_local_zero: assert property (rs |-> !hrdata_out[0] && !hrdata_out[16])
    else $error("local supply bits not zero");
  a_resv_zero: assert property (rs |-> (hrdata_out & 32'h7FFC7FFC) == 32'h0)
    else $error("reserved status bits set");
  a_power_off: assert property (ws && hwdata_in[0] |=> (port_power_state_out & ~ef) == '0)
    else $error("power off missed a port");
  a_power_on: assert property (ws && hwdata_in[16] && !hwdata_in[0] |=> &(port_power_state_out | ef))
    else $error("power on missed a port");
  a_masked_keep: assert property (ws |=> (port_power_state_out & ef) == ($past(port_power_state_out) & ef))
    else $error("masked port moved on global command");
  a_zero_write: assert property (ws && hwdata_in == 32'h0 |=> $stable(port_power_state_out))
    else $error("zero write changed power");
  a_oc_follow: assert property (rs && !ocp_r |-> hrdata_out[1] == $past(overcurrent_in))
    else $error("overcurrent flag wrong");
  a_oc_perport: assert property (rs && ocp_r |-> !hrdata_out[1])
    else $error("overcurrent flag set in per-port mode");
  a_oc_change: assert property (rs && !ocp_r && $past(overcurrent_in) != $past(overcurrent_in, 2) |-> hrdata_out[17])
    else $error("overcurrent change not set");
  a_wake_bit: assert property (rs |-> hrdata_out[15] == wk_r)
    else $error("wake enable readback wrong");
  a_wake_resume: assert property (s_wake |=> s_resume)
    else $error("resume missed");
  a_no_wake: assert property (!wk_r && bus_state_out == 2'h1 && !(dv_r && dw_r) |=> bus_state_out == 2'h1)
    else $error("resume while wake disabled");
endmodule
bind rhg_global_status rhg_global_status_chk u_chk (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .overcurrent_in(overcurrent_in),
  .attach_change_flag_in(attach_change_flag_in),
  .port_power_state_out(port_power_state_out),
  .bus_state_out(bus_state_out),
  .resume_seen_interrupt_out(resume_seen_interrupt_out)
);
`default_nettype wire

// ### tb/rhg_global_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rhg_global_status_tb;
  import rhg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic oc = 1'b0;
  logic rdp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [RHG_NUM_PORTS:1] att = '0;
  logic [31:0] seed = 32'h0000664A;
  logic [31:0] hrdata;
  logic [RHG_NUM_PORTS:1] pwr;
  logic [1:0] bst;
  logic hrdy, hresp, rsm, irq;
  logic [15:0] mk;
  logic [31:0] exq[$];
  int fails = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  rhg_global_status dut (
    .clock_in(clk), .reset_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .overcurrent_in(oc), .attach_change_flag_in(att),
    .port_power_state_out(pwr), .bus_state_out(bst),
    .resume_seen_interrupt_out(rsm), .irq_out(irq)
  );
  ////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= RHG_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    rdp <= !w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rdp <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge clk) begin
    if (rdp && hrdy === 1'b1 && exq.size() > 0) begin
      chk(hrdata === exq.pop_front() && hresp === 1'b0, "read data");
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(RHG_OFS_STATUS, 32'h0);
    wr(RHG_OFS_STATUS, 32'h7FFC7FFC);
    rd(RHG_OFS_STATUS, 32'h0);
    wr(RHG_OFS_STATUS, 32'h0);
    rd(RHG_OFS_PWR, 32'h0);
    wr(RHG_OFS_STATUS, 32'h00010000);
    rd(RHG_OFS_PWR, 32'h0000FFFE);
    wr(RHG_OFS_STATUS, 32'h00000001);
    rd(RHG_OFS_PWR, 32'h0);
    seed = xs(seed);
    mk = {seed[15:1], 1'b0};
    wr(RHG_OFS_MODE, 32'h1);
    wr(RHG_OFS_MASK, {16'h0, mk});
    wr(RHG_OFS_STATUS, 32'h00010000);
    rd(RHG_OFS_PWR, {16'h0, ~mk & 16'hFFFE});
    wr(RHG_OFS_PORTPWR, 32'h0000FFFE);
    wr(RHG_OFS_STATUS, 32'h00000001);
    rd(RHG_OFS_PWR, {16'h0, mk});
    wr(RHG_OFS_MODE, 32'h0);
    wr(RHG_OFS_IRQ_MASK, 32'h3);
    oc <= 1'b1;
    rd(RHG_OFS_STATUS, 32'h00020002);
    chk(irq === 1'b1, "irq level");
    wr(RHG_OFS_STATUS, 32'h00020000);
    rd(RHG_OFS_STATUS, 32'h00000002);
    oc <= 1'b0;
    rd(RHG_OFS_STATUS, 32'h00020000);
    rd(RHG_OFS_IRQ_STAT, 32'h2);
    @(posedge clk);
    chk(irq === 1'b0, "irq cleared");
    wr(RHG_OFS_STATUS, 32'h00020000);
    wr(RHG_OFS_MODE, 32'h2);
    oc <= 1'b1;
    repeat (2) @(posedge clk);
    rd(RHG_OFS_STATUS, 32'h0);
    oc <= 1'b0;
    wr(RHG_OFS_MODE, 32'h0);
    wr(RHG_OFS_STATUS, 32'h00008000);
    rd(RHG_OFS_STATUS, 32'h00008000);
    wr(RHG_OFS_STATUS, 32'h80008000);
    rd(RHG_OFS_STATUS, 32'h0);
    wr(RHG_OFS_SUSPEND, 32'h1);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr(RHG_OFS_STATUS, 32'h00008000);
      seed = xs(seed);
      att <= 15'h0001 << (seed % 32'd15);
      @(posedge clk);
      att <= '0;
      @(posedge clk);
      chk(bst === (i == 1 ? 2'h2 : 2'h1), "bus state");
    end
    rd(RHG_OFS_IRQ_STAT, 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
